// >>> negate_nop_pop_pkg.sv
// package: constants and carriers for the negate / idle / stack-discard decoder
package negate_nop_pop_pkg;
    localparam logic [6:0]  NEG_OP_HI      = 7'h36;    // 0110 110 then a
    localparam logic [15:0] IDLE_WORD      = 16'h0000;
    localparam logic [3:0]  IDLE_NIBBLE    = 4'hF;
    localparam logic [15:0] DISCARD_WORD   = 16'h0006;
    localparam logic [7:0]  ILO_LIMIT      = 8'h5F;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;    // low access half vs sfr half
    localparam logic [3:0]  SFR_BANK       = 4'hF;
    localparam logic [1:0]  Q_LAST         = 2'h3;
    localparam logic [7:0]  ZERO_BYTE      = 8'h00;
    localparam int          FLAG_C         = 0;
    localparam int          FLAG_DC        = 1;
    localparam int          FLAG_Z         = 2;
    localparam int          FLAG_OV        = 3;
    localparam int          FLAG_N         = 4;

    typedef enum logic [1:0] {EX_IDLE, EX_NEG, EX_DISCARD} exec_e;

    typedef struct packed {
        logic        rd_en;
        logic        wr_en;
        logic [13:0] addr;
        logic [7:0]  wdata;
    } mem_req_s;

    typedef struct packed {
        logic       flag_we;
        logic [4:0] flags;
        logic       stack_pop;
        logic       done;
    } core_upd_s;
endpackage : negate_nop_pop_pkg

// >>> negate_nop_pop_decode.sv
// module: decodes and executes negate, idle and stack-discard instruction words
module negate_nop_pop_decode
    import negate_nop_pop_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        insn_valid,
    input  wire logic [15:0] insn_word,
    input  wire logic [5:0]  bank_select_register,
    input  wire logic [13:0] index_base,
    input  wire logic        ext_set_en,
    input  wire logic [7:0]  mem_rdata,
    output mem_req_s         mem,
    output core_upd_s        upd,
    output logic [1:0]       q_phase
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0]  q;
        exec_e       op;
        logic        busy;
        logic [15:0] word;
        logic [13:0] addr;
        mem_req_s    mem;
        core_upd_s   upd;
    } state_s;

    state_s st_r, st_nxt;
    logic [7:0] neg_res;
    logic [4:0] neg_flags;
    logic [4:0] lo_sum;
    logic       is_neg, is_idle, is_disc;
    logic [13:0] ea;

    assign is_neg  = insn_word[15:9] == NEG_OP_HI;
    assign is_disc = insn_word == DISCARD_WORD;
    assign is_idle = insn_word == IDLE_WORD || insn_word[15:12] == IDLE_NIBBLE;

    ////////////////////////////////////////////////////////////////////////
    // effective address of the file operand
    // indexed base + offset wraps at 14 bits; software keeps the sum in range
    always_comb begin
        if (!insn_word[8]) begin
            if (ext_set_en && insn_word[7:0] <= ILO_LIMIT)
                ea = index_base + {6'h00, insn_word[7:0]};
            else if (insn_word[7:0] < ACCESS_SPLIT)
                ea = {6'h00, insn_word[7:0]};
            else
                ea = {2'h0, SFR_BANK, 8'hFF} - {6'h00, 8'hFF - insn_word[7:0]};
        end else begin
            ea = {bank_select_register, insn_word[7:0]};
        end
    end

    // two's complement: ~f + 1, flags from that add
    // mem_rdata must be settled while q_phase is 2: the result comes straight off it
    assign neg_res = ZERO_BYTE - mem_rdata;
    assign lo_sum  = {1'b0, ~mem_rdata[3:0]} + 5'h01;
    always_comb begin
        neg_flags         = '0;
        neg_flags[FLAG_C]  = mem_rdata == ZERO_BYTE;
        neg_flags[FLAG_DC] = lo_sum[4];
        neg_flags[FLAG_Z]  = neg_res == ZERO_BYTE;
        neg_flags[FLAG_OV] = mem_rdata == 8'h80;
        neg_flags[FLAG_N]  = neg_res[7];
    end

    ////////////////////////////////////////////////////////////////////////
    // quarter phases run free; a word is taken at q0 (q==0)
    // schedule per instruction cycle, one quarter per clock:
    //   q0 edge: latch word, op and address; raise the read strobe for negate
    //   q1 edge: discard raises the pop strobe
    //   q2 edge: negate result and flags go out with the write strobe
    //   q3 edge: done for whatever word was taken
    always_comb begin
        st_nxt     = st_r;
        st_nxt.q   = st_r.q + 2'h1;
        st_nxt.mem = '0;
        st_nxt.upd = '0;
        unique case (st_r.q)
            2'h0: begin
                st_nxt.busy = insn_valid;
                st_nxt.word = insn_word;
                st_nxt.addr = ea;
                if (is_neg)
                    st_nxt.op = EX_NEG;
                else if (is_disc)
                    st_nxt.op = EX_DISCARD;
                else
                    st_nxt.op = EX_IDLE;
                if (insn_valid && is_neg) begin
                    st_nxt.mem.rd_en = 1'b1;
                    st_nxt.mem.addr  = ea;
                end
            end
            2'h1: begin
                // discard pop seen in q2: flags untouched, one cycle
                if (st_r.busy && st_r.op == EX_DISCARD)
                    st_nxt.upd.stack_pop = 1'b1;
            end
            2'h2: begin
                if (st_r.busy && st_r.op == EX_NEG) begin
                    st_nxt.mem.wr_en   = 1'b1;
                    st_nxt.mem.addr    = st_r.addr;
                    st_nxt.mem.wdata   = neg_res;
                    st_nxt.upd.flag_we = 1'b1;
                    st_nxt.upd.flags   = neg_flags;
                end
            end
            2'h3: begin
                st_nxt.upd.done = st_r.busy;
                st_nxt.busy     = 1'b0;
            end
        endcase
        if (is_idle && st_r.q == 2'h0)
            st_nxt.busy = insn_valid;
    end

    always_ff @(posedge sys_clk) begin
        if (srst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign mem     = st_r.mem;
    assign upd     = st_r.upd;
    assign q_phase = st_r.q;

    ////////////////////////////////////////////////////////////////////////
    // negate: read strobe seen in q1, write and flags seen in q3
    a_neg_write_value: assert property (@(posedge sys_clk) disable iff (srst)
        (st_r.q == 2'h2 && st_r.busy && st_r.op == EX_NEG) |=>
            mem.wr_en && mem.wdata == ~$past(mem_rdata) + 8'h01
            && upd.flag_we)
        else $error("negate write missing or wrong");
    a_neg_read_first: assert property (@(posedge sys_clk) disable iff (srst)
        mem.wr_en |-> $past(mem.rd_en, 2) && mem.addr == $past(mem.addr, 2))
        else $error("negate write without matching read");

    // operand addressing, checked one cycle after the word is taken
    a_access_bank: assert property (@(posedge sys_clk) disable iff (srst)
        (q_phase == 2'h0 && insn_valid && is_neg && !insn_word[8] && !ext_set_en && insn_word[7:0] < 8'h60)
            |=> mem.addr == {6'h00, $past(insn_word[7:0])})
        else $error("access bank address wrong");
    a_bank_select: assert property (@(posedge sys_clk) disable iff (srst)
        (q_phase == 2'h0 && insn_valid && is_neg && insn_word[8])
            |=> mem.addr == {$past(bank_select_register), $past(insn_word[7:0])})
        else $error("banked address wrong");
    a_indexed_mode: assert property (@(posedge sys_clk) disable iff (srst)
        (q_phase == 2'h0 && insn_valid && is_neg && !insn_word[8] && ext_set_en && insn_word[7:0] <= 8'h5F)
            |=> mem.addr == $past(index_base) + {6'h00, $past(insn_word[7:0])})
        else $error("indexed literal offset address wrong");

    // stack discard: one pop, seen in the third quarter, nothing else
    a_discard_once: assert property (@(posedge sys_clk) disable iff (srst)
        (q_phase == 2'h0 && insn_valid && is_disc) |=> ##1 upd.stack_pop ##1 !upd.stack_pop && !upd.flag_we)
        else $error("stack discard not single pulse");
    a_pop_no_flags: assert property (@(posedge sys_clk) disable iff (srst)
        upd.stack_pop |-> !upd.flag_we && !mem.wr_en && q_phase == 2'h2)
        else $error("discard disturbed other state");

    // idle words: no strobe, done only when a word was really offered
    a_idle_quiet: assert property (@(posedge sys_clk) disable iff (srst)
        (q_phase == 2'h0 && is_idle) |=> (!mem.rd_en && !upd.stack_pop)[*3] ##1 upd.done == $past(insn_valid, 4))
        else $error("idle word changed state");

    ////////////////////////////////////////////////////////////////////////
    // every event owns one quarter; read and write of the same byte never
    // share a cycle, which is what keeps the read-modify-write hazard free
    a_quarter_step: assert property (@(posedge sys_clk) disable iff (srst)
        1'b1 |=> q_phase == $past(q_phase) + 2'h1)
        else $error("quarter counter did not advance");
    a_read_slot: assert property (@(posedge sys_clk) disable iff (srst)
        mem.rd_en |-> q_phase == 2'h1 && !mem.wr_en)
        else $error("operand read outside second quarter");
    a_write_slot: assert property (@(posedge sys_clk) disable iff (srst)
        mem.wr_en |-> q_phase == 2'h3 && upd.flag_we)
        else $error("operand write outside last quarter");
    a_done_slot: assert property (@(posedge sys_clk) disable iff (srst)
        upd.done |-> q_phase == 2'h0 && !mem.wr_en && !upd.stack_pop)
        else $error("done pulse out of place");

    // flags judged from the operand alone, not from the adder
    a_neg_flag_value: assert property (@(posedge sys_clk) disable iff (srst)
        (q_phase == 2'h2 && st_r.busy && st_r.op == EX_NEG) |=>
            upd.flags[FLAG_C] == ($past(mem_rdata) == 8'h00)
            && upd.flags[FLAG_DC] == (($past(mem_rdata) & 8'h0F) == 8'h00)
            && upd.flags[FLAG_Z] == ($past(mem_rdata) == 8'h00)
            && upd.flags[FLAG_OV] == ($past(mem_rdata) == 8'h80)
            && upd.flags[FLAG_N] == ($past(mem_rdata) != 8'h00 && $past(mem_rdata) <= 8'h80))
        else $error("negate flags wrong");
    a_flags_only_neg: assert property (@(posedge sys_clk) disable iff (srst)
        upd.flag_we |-> $past(insn_valid, 3) && $past(is_neg, 3))
        else $error("flag write without negate word");

    // upper access half lands in bank 15 (SFR_BANK)
    a_access_upper: assert property (@(posedge sys_clk) disable iff (srst)
        (q_phase == 2'h0 && insn_valid && is_neg && !insn_word[8] && insn_word[7:0] >= 8'h60)
            |=> mem.addr == {6'h0F, $past(insn_word[7:0])})
        else $error("upper access half address wrong");

    a_discard_no_mem: assert property (@(posedge sys_clk) disable iff (srst)
        (q_phase == 2'h0 && insn_valid && is_disc)
            |=> (!mem.rd_en && !mem.wr_en && !upd.flag_we)[*4])
        else $error("stack discard touched memory or flags");
    a_pop_from_discard: assert property (@(posedge sys_clk) disable iff (srst)
        upd.stack_pop |-> $past(insn_valid, 2) && $past(is_disc, 2))
        else $error("stack pop without discard word");

    // idle, unknown and absent words must leave no trace
    a_idle_no_write: assert property (@(posedge sys_clk) disable iff (srst)
        (q_phase == 2'h0 && is_idle)
            |=> (!mem.wr_en && !upd.flag_we)[*3])
        else $error("idle word wrote memory or flags");
    a_unknown_quiet: assert property (@(posedge sys_clk) disable iff (srst)
        (q_phase == 2'h0 && insn_valid && !is_neg && !is_disc)
            |=> (!mem.rd_en && !mem.wr_en && !upd.stack_pop && !upd.flag_we)[*3] ##1 upd.done)
        else $error("non-executing word disturbed state");
    a_no_word_quiet: assert property (@(posedge sys_clk) disable iff (srst)
        (q_phase == 2'h0 && !insn_valid)
            |=> (!mem.rd_en && !mem.wr_en && !upd.stack_pop && !upd.flag_we)[*3] ##1 !upd.done)
        else $error("absent word produced activity");
endmodule : negate_nop_pop_decode

// >>> mem_stack_model.sv
// partner model: data memory and return stack beside the decoder
module mem_stack_model
    import negate_nop_pop_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire mem_req_s  mem,
    input  wire core_upd_s upd,
    output logic [7:0]     mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  ram [0:16383];
    logic [20:0] stk [0:7];
    int          sp        = 0;
    logic [13:0] rd_addr_r = 14'h0000;
    logic        rd_live_r = 1'b0;
    logic [7:0]  noise_r   = 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    // churn outside the read slot so stale data is never trusted
    assign mem_rdata = rd_live_r ? ram[rd_addr_r] : noise_r;
    always @(posedge sys_clk) begin
        noise_r <= noise_r + 8'h3B;
        rd_live_r <= mem.rd_en;
        if (mem.rd_en) rd_addr_r <= mem.addr;
        if (mem.wr_en) ram[mem.addr] <= mem.wdata;
        if (upd.stack_pop && sp > 0) sp <= sp - 1;
    end
endmodule : mem_stack_model

// >>> negate_nop_pop_decode_test.sv
// testbench: negate, idle and stack-discard scenarios against the partner model
module negate_nop_pop_decode_test import negate_nop_pop_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 0, srst = 1, insn_valid = 0, ext_set_en = 0;
    logic [15:0] insn_word = 16'h0000;
    logic [5:0]  bank_select_register = 6'h00;
    logic [13:0] index_base = 14'h0000;
    logic [7:0]  mem_rdata;
    mem_req_s    mem;
    core_upd_s   upd;
    logic [1:0]  q_phase;
    logic [4:0]  flags_seen;
    logic        flag_we_seen, pop_seen;
    int          failures = 0, compares = 0, wr_seen;
    negate_nop_pop_decode dut (.sys_clk(sys_clk), .srst(srst), .insn_valid(insn_valid), .insn_word(insn_word),
        .bank_select_register(bank_select_register), .index_base(index_base), .ext_set_en(ext_set_en),
        .mem_rdata(mem_rdata), .mem(mem), .upd(upd), .q_phase(q_phase));
    mem_stack_model model (.sys_clk(sys_clk), .mem(mem), .upd(upd), .mem_rdata(mem_rdata));
    always #4 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        if (failures == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // words only count when offered in the first quarter
    task automatic run(input logic [15:0] word);
        int n;
        {flag_we_seen, pop_seen, wr_seen, flags_seen, n} = '0;
        while (q_phase !== 2'h0) begin
            @(posedge sys_clk) #1;
            if (++n > 8) begin failures++; stop_test(); end
        end
        insn_word = word;
        insn_valid = 1;
        @(posedge sys_clk) #1;
        insn_valid = 0;
        for (n = 0; n < 6 && upd.done !== 1'b1; n++) begin
            if (upd.flag_we === 1'b1) begin flag_we_seen = 1; flags_seen = upd.flags; end
            pop_seen |= (upd.stack_pop === 1'b1);
            wr_seen += int'(mem.wr_en === 1'b1);
            @(posedge sys_clk) #1;
        end
        if (upd.done !== 1'b1) begin failures++; stop_test(); end
    endtask : run
    task automatic neg_case(input logic [15:0] word, input logic [13:0] addr, input logic [7:0] val,
                            input logic [4:0] exp_flags);
        model.ram[addr] = val;
        run(word);
        check(21'(model.ram[addr]), 21'(8'(~val + 8'h01)));
        check(21'({flag_we_seen, flags_seen}), 21'({1'b1, exp_flags}));
    endtask : neg_case
    task automatic t_neg_access;
        ext_set_en = 0;
        neg_case(16'h6C3A, 14'h003A, 8'h3A, 5'h10);
        ext_set_en = 1;
        neg_case(16'h6C60, 14'h0F60, 8'h01, 5'h10);
    endtask : t_neg_access
    task automatic t_neg_banked;
        bank_select_register = 6'h05;
        neg_case(16'h6D80, 14'h0580, 8'h80, 5'h1A);
    endtask : t_neg_banked
    task automatic t_neg_indexed;
        ext_set_en = 1;
        index_base = 14'h0200;
        neg_case(16'h6C5F, 14'h025F, 8'h00, 5'h07);
    endtask : t_neg_indexed
    task automatic t_discard;
        model.stk[0] = 21'h014332;
        model.stk[1] = 21'h0031A2;
        model.sp = 2;
        run(DISCARD_WORD);
        check(21'({pop_seen, flag_we_seen}), 21'h2);
        check(model.stk[model.sp - 1], 21'h014332);
    endtask : t_discard
    task automatic t_idle;
        run(IDLE_WORD);
        check(21'({pop_seen, flag_we_seen, 8'(wr_seen), 11'(model.sp)}), 21'h1);
        run(16'hF123);
        check(21'({pop_seen, flag_we_seen, 8'(wr_seen), 11'(model.sp)}), 21'h1);
    endtask : t_idle
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 srst = 0;
        t_neg_access();
        t_neg_banked();
        t_neg_indexed();
        t_discard();
        t_idle();
        stop_test();
    end
endmodule : negate_nop_pop_decode_test
